//--- logic/dip_dma_seq.sv
/*
 * dip_dma_seq: master-side sequencer for init block and descriptor DMA,
 * with parity error response and orderly transmit termination.
 * assumes: an outside bus front end turns the phase strobes into pin
 * timing and reports target ready and parity errors on this clock.
 */
// Operation
// - master parity error sets flag, interrupt if enabled
// - default mode: parity error only sets flag
// - advanced enable marks buffer errors, bit 23
// - init read error sets stop bit
// - ring error: terminate network, then stop
// - tx buffer error: mark descriptor, terminate
// - rx buffer error: mark last descriptor
// - under 512 bits runt, else bad fcs
// - advanced enable ignores address and target errors
// - init request: two dword reads, release
// - 32-bit init: seven dwords, four periods
// - 16-bit init: three periods
// - no read burst: separate address phases
// - read burst: single burst, linear order
// - descriptor read two, write one or two
// - reads all lanes, writes needed lanes only
// - descriptor read burst only style 3 with enable; init read burst with enable alone
// - write burst only style 3 with enable
// - chained intermediate: single byte or word write
// - last descriptor: dword then ownership write
// - descriptor writes add one wait state
module dip_dma_seq
    import dip_pkg::*;
#(
    parameter int AW = DIP_AW                        // address width
) (
    input  wire logic                  mclk,          // 100 MHz clock
    input  wire logic                  rst_n,         // sync reset
    input  wire logic                  ce,            // clock enable
    input  wire logic                  req,           // microcode request pulse
    input  wire dip_pkg::dip_op_t      req_op,        // init/read/write
    input  wire logic [AW-1:0]         req_addr,      // descriptor or block base
    input  wire logic                  req_chain_mid, // intermediate chained desc
    input  wire logic [31:0]           wr_status,     // first status dword
    input  wire logic [31:0]           wr_word1,      // descriptor_word1 value
    input  wire logic [7:0]            software_style_field, // style
    input  wire logic                  init_structure_32bit, // 32-bit init
    input  wire logic                  burst_read_enable,    // read bursting
    input  wire logic                  burst_write_enable,   // write bursting
    input  wire logic                  advanced_parity_enable, // adv mode
    input  wire logic                  system_error_interrupt_enable, // int enable
    input  wire logic                  system_error_interrupt_flag_clr,      // clear flag
    input  wire logic                  bus_ready,     // target ready for data
    input  wire logic                  data_perr,     // data parity error seen
    input  wire logic                  addr_perr,     // address parity error
    input  wire logic                  target_perr,   // error while target
    input  wire logic                  buf_perr,      // fifo buffer parity error
    input  wire logic                  buf_is_tx,     // buffer error on tx side
    input  wire logic                  tx_active,     // transmission running
    input  wire logic [15:0]           tx_bytes,      // bytes sent
    input  wire logic                  tx_byte_end,   // byte boundary
    output logic                       busy,          // sequencer busy
    output logic                       addr_valid,    // address phase
    output logic [AW-1:0]              addr,          // address
    output logic                       frame,         // frame active
    output logic                       irdy,          // master data ready
    output logic                       wr,            // write cycle
    output logic [3:0]                 byte_en,       // byte enables, high active
    output logic [31:0]                wdata,         // write data
    output logic                       rd_take,       // read data to keep
    output logic                       done,          // request finished
    output logic                       init_done,     // init sequence complete
    output logic                       system_error_interrupt_flag, // flag
    output logic                       intr,          // interrupt line
    output logic                       stop_set,      // stop bit set pulse
    output logic                       bpe_tx,        // set bpe in tx desc
    output logic                       bpe_rx,        // set bpe in rx desc
    output logic                       tx_abort,      // runt stop
    output logic                       tx_bad_fcs     // inverted fcs
);
    import dip_pkg::*;

    dip_state_t      st_r, st_nxt;
    dip_op_t         op_r;
    logic [AW-1:0]   addr_r;
    logic [1:0]      cnt_r, total_r;
    logic            burst_r, wr_r;
    logic [2:0]      per_r;
    logic [2:0]      dw_r;
    logic [31:0]     wd0_r, wd1_r;
    logic [3:0]      be0_r, be1_r;
    logic            chain_r;
    logic            done_r, idone_r, take_r;
    logic [AW-1:0]   a_first;

    wire style3      = software_style_field == DIP_STYLE_32_BURST;
    wire style16     = software_style_field == DIP_STYLE_16;
    wire is_wr_req   = req_op == DIP_OP_DWR;
    // init: read burst per enable; descriptors: style 3 only
    wire want_burst  = (req_op == DIP_OP_INIT) ? burst_read_enable :
                       is_wr_req ? (style3 && burst_write_enable) : (style3 && burst_read_enable);
    wire [1:0] n_xfer = (is_wr_req && req_chain_mid) ? 2'h1 : DIP_INIT_XFERS;
    wire [2:0] per_need = init_structure_32bit ? DIP_INIT_PER_32 : DIP_INIT_PER_16;
    wire last_xfer   = cnt_r == total_r - 2'h1;
    wire first_xfer  = cnt_r == 2'h0;

    // style 0 intermediate writes a byte, styles 2/3 a word
    wire [3:0] own_be = style16 ? DIP_BE_TOP_BYTE : DIP_BE_TOP_WORD;
    // address order: style 3 burst writes status at +0 then word1 at +4
    assign a_first = req_addr;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            DIP_S_IDLE: if (req) st_nxt = DIP_S_ADDR;
            // write data phases are stretched by one wait cycle
            DIP_S_ADDR: st_nxt = wr_r ? DIP_S_WAIT : DIP_S_DATA;
            DIP_S_WAIT: st_nxt = DIP_S_DATA;
            DIP_S_DATA: begin
                if (bus_ready) begin
                    if (last_xfer)
                        st_nxt = DIP_S_IDLE;
                    else if (burst_r)
                        st_nxt = wr_r ? DIP_S_WAIT : DIP_S_DATA;
                    else
                        st_nxt = DIP_S_GAP;
                end
            end
            DIP_S_GAP: st_nxt = DIP_S_ADDR;
            default: st_nxt = DIP_S_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r    <= DIP_S_IDLE;
            op_r    <= DIP_OP_INIT;
            addr_r  <= '0;
            cnt_r   <= 2'h0;
            total_r <= 2'h0;
            burst_r <= 1'b0;
            wr_r    <= 1'b0;
            chain_r <= 1'b0;
            wd0_r   <= 32'h0000_0000;
            wd1_r   <= 32'h0000_0000;
            be0_r   <= 4'h0;
            be1_r   <= 4'h0;
            per_r   <= 3'h0;
            dw_r    <= 3'h0;
            done_r  <= 1'b0;
            idone_r <= 1'b0;
            take_r  <= 1'b0;
        end else if (ce) begin
            st_r    <= st_nxt;
            done_r  <= 1'b0;
            idone_r <= 1'b0;
            take_r  <= 1'b0;
            if (st_r == DIP_S_IDLE && req) begin
                op_r    <= req_op;
                addr_r  <= a_first;
                cnt_r   <= 2'h0;
                total_r <= n_xfer;
                burst_r <= want_burst;
                wr_r    <= is_wr_req;
                chain_r <= req_chain_mid;
                // all lanes on reads; only written lanes on writes
                be0_r   <= !is_wr_req ? DIP_BE_ALL : (req_chain_mid ? own_be : DIP_BE_ALL);
                be1_r   <= !is_wr_req ? DIP_BE_ALL : own_be;
                wd0_r   <= req_chain_mid ? wr_word1 : wr_status;
                wd1_r   <= wr_word1;  // ownership bit rides in word1 top
            end
            if (st_r == DIP_S_DATA && bus_ready) begin
                cnt_r   <= cnt_r + 2'h1;
                // contiguous ascending addresses
                addr_r  <= addr_r + AW'(DIP_ADDR_STEP);
                take_r  <= !wr_r;
                if (op_r == DIP_OP_INIT) begin
                    dw_r <= dw_r + 3'h1;  // eighth dword is discarded by the consumer
                end
                if (last_xfer) begin
                    done_r <= 1'b1;
                    if (op_r == DIP_OP_INIT) begin
                        if (per_r + 3'h1 >= per_need) begin
                            per_r   <= 3'h0;
                            dw_r    <= 3'h0;
                            idone_r <= 1'b1;
                        end else begin
                            per_r <= per_r + 3'h1;
                        end
                    end
                end
            end
        end
    end

    assign busy       = st_r != DIP_S_IDLE;
    // burst address phases drive a dword-aligned address, linear order
    assign addr       = burst_r ? {addr_r[AW-1:2], 2'b00} : addr_r;
    assign addr_valid = st_r == DIP_S_ADDR;
    assign frame      = (st_r == DIP_S_ADDR) || (st_r == DIP_S_WAIT) ||
                        (st_r == DIP_S_DATA && !last_xfer && burst_r);
    assign irdy       = st_r == DIP_S_DATA;
    assign wr         = wr_r;
    assign byte_en    = first_xfer ? be0_r : be1_r;
    assign wdata      = first_xfer ? wd0_r : wd1_r;
    assign rd_take    = take_r;
    assign done       = done_r;
    assign init_done  = idone_r;

    // only master data errors and buffer errors reach the handler; address and target errors do not
    wire net_idle, term_req;
    wire perr_master = (busy && data_perr && bus_ready) || buf_perr;
    wire dip_op_t err_op = buf_perr ? DIP_OP_BUF : op_r;
    logic unused_perr;
    assign unused_perr = addr_perr | target_perr;

    dip_parity_resp u_resp (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .ce          (ce),
        .perr_master (perr_master),
        .op          (err_op),
        .buf_is_tx   (buf_is_tx),
        .adv_en      (advanced_parity_enable),
        .system_error_interrupt_flag_en     (system_error_interrupt_enable),
        .system_error_interrupt_flag_clr    (system_error_interrupt_flag_clr),
        .net_idle    (net_idle),
        .system_error_interrupt_flag_flag   (system_error_interrupt_flag),
        .intr        (intr),
        .stop_set    (stop_set),
        .tx_term     (term_req),
        .bpe_tx      (bpe_tx),
        .bpe_rx      (bpe_rx)
    );

    dip_tx_term u_term (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .ce          (ce),
        .term_req    (term_req),
        .tx_active   (tx_active),
        .tx_bytes    (tx_bytes),
        .tx_byte_end (tx_byte_end),
        .tx_abort    (tx_abort),
        .tx_bad_fcs  (tx_bad_fcs),
        .idle        (net_idle)
    );

    sequence s_wr_addr;
        ce && st_r == DIP_S_ADDR && wr_r;
    endsequence
    sequence s_wait_then_data;
        !irdy ##1 irdy;
    endsequence

    a_wr_wait_state: assert property (@(posedge mclk) disable iff (!rst_n)
        s_wr_addr |=> s_wait_then_data) else $error("no wait state");
    // burst writes fall back to the wait cycle between data phases as well
    a_burst_wr_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && irdy && bus_ready && wr_r && burst_r && !last_xfer |=> s_wait_then_data) else $error("no burst wait");
    // the final init period ends after two dwords per period; extra ones are dropped downstream
    a_init_dwords: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && irdy && bus_ready && op_r == DIP_OP_INIT && last_xfer && (per_r + 3'h1 >= per_need)
        |-> {1'b0, dw_r} == {per_need, 1'b0} - 4'h1) else $error("init dword count");
    a_read_lanes: assert property (@(posedge mclk) disable iff (!rst_n)
        irdy && !wr_r |-> byte_en == DIP_BE_ALL) else $error("read lanes");
    a_nonburst_gap: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && irdy && bus_ready && !burst_r && !last_xfer |=> !frame ##1 addr_valid) else $error("gap");
    a_burst_style: assert property (@(posedge mclk) disable iff (!rst_n)
        busy && burst_r && op_r != DIP_OP_INIT |-> style3) else $error("burst style");
    a_burst_align: assert property (@(posedge mclk) disable iff (!rst_n)
        addr_valid && burst_r |-> addr[1:0] == 2'b00) else $error("burst align");
    a_init_two: assert property (@(posedge mclk) disable iff (!rst_n)
        busy && op_r == DIP_OP_INIT |-> total_r == DIP_INIT_XFERS) else $error("init count");
    a_chain_one: assert property (@(posedge mclk) disable iff (!rst_n)
        busy && wr_r && chain_r |-> total_r == 2'h1 && byte_en != DIP_BE_ALL) else $error("chain write");
endmodule

//--- logic/dip_pkg.sv
/*
 * dip_pkg: constants and types shared by the descriptor/init DMA sequencer.
 * assumes: single 100 MHz clock domain, synchronous active-low reset.
 */
package dip_pkg;
    localparam int          DIP_AW             = 32;
    localparam int          DIP_DW             = 32;
    // software style encodings
    localparam logic [7:0]  DIP_STYLE_16       = 8'h00;
    localparam logic [7:0]  DIP_STYLE_32       = 8'h02;
    localparam logic [7:0]  DIP_STYLE_32_BURST = 8'h03;
    // descriptor word 1 field positions
    localparam int          DIP_BPE_BIT        = 23;
    localparam int          DIP_OWN_BIT        = 31;
    // init block: transfers per period, periods per style
    localparam logic [1:0]  DIP_INIT_XFERS     = 2'h2;
    localparam logic [2:0]  DIP_INIT_PER_32    = 3'h4;
    localparam logic [2:0]  DIP_INIT_PER_16    = 3'h3;
    // orderly termination threshold in bits, and as bytes
    localparam int          DIP_RUNT_BITS      = 512;
    localparam logic [15:0] DIP_RUNT_BYTES     = 16'(DIP_RUNT_BITS / 8);
    // byte enables (active high here)
    localparam logic [3:0]  DIP_BE_ALL         = 4'hf;
    localparam logic [3:0]  DIP_BE_TOP_BYTE    = 4'h8;
    localparam logic [3:0]  DIP_BE_TOP_WORD    = 4'hc;
    localparam logic [DIP_DW-1:0] DIP_ADDR_STEP = 32'h0000_0004;

    typedef enum logic [1:0] {
        DIP_OP_INIT  = 2'h0,
        DIP_OP_DRD   = 2'h1,
        DIP_OP_DWR   = 2'h2,
        DIP_OP_BUF   = 2'h3
    } dip_op_t;

    // gray codes along idle -> address -> wait -> data -> gap
    typedef enum logic [2:0] {
        DIP_S_IDLE   = 3'b000,
        DIP_S_ADDR   = 3'b001,
        DIP_S_WAIT   = 3'b011,
        DIP_S_DATA   = 3'b010,
        DIP_S_GAP    = 3'b110
    } dip_state_t;
endpackage

//--- logic/dip_parity_resp.sv
/*
 * dip_parity_resp: reacts to master data parity errors.
 * assumes: errors arrive as one-cycle pulses tagged by the current transfer kind.
 */
module dip_parity_resp
    import dip_pkg::*;
(
    input  wire logic    mclk,          // clock
    input  wire logic    rst_n,         // sync reset
    input  wire logic    ce,            // clock enable
    input  wire logic    perr_master,   // parity error while master
    input  wire dip_op_t op,            // transfer kind at error
    input  wire logic    buf_is_tx,     // buffer error is on transmit side
    input  wire logic    adv_en,        // advanced_parity_enable
    input  wire logic    system_error_interrupt_flag_en,       // system_error_interrupt_enable
    input  wire logic    system_error_interrupt_flag_clr,      // clears the flag
    input  wire logic    net_idle,      // orderly termination done
    output logic         system_error_interrupt_flag_flag,     // system_error_interrupt_flag
    output logic         intr,          // interrupt line
    output logic         stop_set,      // stop bit set pulse
    output logic         tx_term,       // request orderly tx termination
    output logic         bpe_tx,        // mark tx descriptor
    output logic         bpe_rx         // mark rx descriptor
);
    logic system_error_interrupt_flag_r, pend_r, stop_r, term_r, btx_r, brx_r;
    wire  is_ring = (op == DIP_OP_DRD) || (op == DIP_OP_DWR);
    wire  fire    = perr_master && adv_en;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            system_error_interrupt_flag_r <= 1'b0;
            pend_r <= 1'b0;
            stop_r <= 1'b0;
            term_r <= 1'b0;
            btx_r  <= 1'b0;
            brx_r  <= 1'b0;
        end else if (ce) begin
            // set wins over clear; parity report enable is not consulted
            system_error_interrupt_flag_r <= perr_master | (system_error_interrupt_flag_r & ~system_error_interrupt_flag_clr);
            stop_r <= (fire && op == DIP_OP_INIT) || (pend_r && net_idle);
            pend_r <= (fire && is_ring) | (pend_r & ~net_idle);
            term_r <= fire && (is_ring || (op == DIP_OP_BUF && buf_is_tx));
            btx_r  <= fire && op == DIP_OP_BUF && buf_is_tx;
            brx_r  <= fire && op == DIP_OP_BUF && !buf_is_tx;
        end
    end
    // default mode leaves engine untouched: all actions gated by adv_en
    assign system_error_interrupt_flag_flag = system_error_interrupt_flag_r;
    assign intr      = system_error_interrupt_flag_r & system_error_interrupt_flag_en;
    assign stop_set  = stop_r;
    assign tx_term   = term_r;
    assign bpe_tx    = btx_r;
    assign bpe_rx    = brx_r;

    a_system_error_interrupt_flag_sets: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && perr_master |=> system_error_interrupt_flag_flag) else $error("flag not set");
    a_default_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && perr_master && !adv_en && !pend_r |=> !stop_set && !tx_term) else $error("default acted");
    a_init_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && fire && op == DIP_OP_INIT |=> stop_set) else $error("no stop");
    a_rx_bpe: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && fire && op == DIP_OP_BUF && !buf_is_tx |=> bpe_rx && !tx_term) else $error("rx bpe");
endmodule

//--- logic/dip_tx_term.sv
/*
 * dip_tx_term: orderly termination of an ongoing transmission.
 * assumes: the MAC reports byte count sent and byte boundaries each cycle.
 */
module dip_tx_term
    import dip_pkg::*;
(
    input  wire logic        mclk,        // clock
    input  wire logic        rst_n,       // sync reset
    input  wire logic        ce,          // clock enable
    input  wire logic        term_req,    // terminate request pulse
    input  wire logic        tx_active,   // transmission in progress
    input  wire logic [15:0] tx_bytes,    // bytes sent so far
    input  wire logic        tx_byte_end, // at a byte boundary
    output logic             tx_abort,    // stop now (runt)
    output logic             tx_bad_fcs,  // append inverted fcs
    output logic             idle         // nothing left to terminate
);
    logic wait_r, abort_r, bad_r;
    wire  short_frame = tx_bytes < DIP_RUNT_BYTES;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wait_r  <= 1'b0;
            abort_r <= 1'b0;
            bad_r   <= 1'b0;
        end else if (ce) begin
            abort_r <= term_req && tx_active && short_frame;
            // long frames wait for the byte boundary before corrupting fcs
            wait_r  <= (term_req && tx_active && !short_frame) | (wait_r & ~tx_byte_end);
            bad_r   <= wait_r && tx_byte_end;
        end
    end
    assign tx_abort   = abort_r;
    assign tx_bad_fcs = bad_r;
    assign idle       = !tx_active && !wait_r;

    a_runt_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && term_req && tx_active && short_frame |=> tx_abort && !tx_bad_fcs) else $error("runt");
endmodule

//--- sim/dip_mem_model.sv
/*
 * dip_mem_model: behavioural memory target facing the DMA sequencer.
 * assumes: master holds irdy until bus_ready, one clock domain.
 */
module dip_mem_model (
    input  wire logic       mclk,      // clock
    input  wire logic       rst_n,     // sync reset
    input  wire logic       irdy,      // master data ready
    input  wire logic [1:0] lat,       // wait cycles before ready
    input  wire logic       perr_on,   // corrupt parity on data phases
    output logic            bus_ready, // data phase completes
    output logic            data_perr  // parity error with the data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_r;
    // ready only after the programmed latency, which the testbench holds at one wait cycle
    assign bus_ready = irdy & (cnt_r >= lat);
    assign data_perr = perr_on & bus_ready;
    always_ff @(posedge mclk) begin
        cnt_r <= (!rst_n || !irdy || bus_ready) ? 2'h0 : cnt_r + 2'h1;
    end
endmodule

//--- sim/tb_dip_dma_seq.sv
/*
 * tb_dip_dma_seq: directed scenarios for init, descriptor and parity handling.
 * assumes: dip_pkg compiled first; ce held high throughout.
 */
module tb_dip_dma_seq;
    timeunit 1ns;
    timeprecision 1ps;
    import dip_pkg::*;
    logic mclk = 0, rst_n = 0, req = 0, chain = 0, system_error_interrupt_flag_en = 0, system_error_interrupt_flag_clr = 0, perr_on = 0;
    logic adv = 0, bre = 0, bwe = 0, s32 = 1, buf_perr = 0, is_tx = 0, tx_act = 0, b_end = 0, aperr = 0;
    logic [1:0] lat = 2'h1;
    logic [15:0] tx_bytes = 16'h0000;
    logic [7:0] style = DIP_STYLE_32;
    dip_op_t op = DIP_OP_INIT;
    logic busy, addr_valid, frame, irdy, wr, rd_take, done, init_done, flag, intr, stop_set;
    logic bpe_tx, bpe_rx, tx_abort, tx_bad_fcs, bus_ready, data_perr;
    logic [31:0] addr, wdata, addrs[8], wds[8];
    logic [3:0] byte_en, bes[8];
    int na, nd, nw, nstop, nab, nfcs, nbpe, nbr, nid, nrt, miscompares = 0, total_checks = 0;
    initial forever #5 mclk = ~mclk;
    dip_mem_model i_dip_mem_model (.mclk(mclk), .rst_n(rst_n), .irdy(irdy), .lat(lat), .perr_on(perr_on),
        .bus_ready(bus_ready), .data_perr(data_perr));
    dip_dma_seq i_dip_dma_seq (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .req(req), .req_op(op),
        .req_addr(32'h0000_1000), .req_chain_mid(chain), .wr_status(32'h1234_5678), .wr_word1(32'h8000_0000),
        .software_style_field(style), .init_structure_32bit(s32), .burst_read_enable(bre),
        .burst_write_enable(bwe), .advanced_parity_enable(adv), .system_error_interrupt_enable(system_error_interrupt_flag_en),
        .system_error_interrupt_flag_clr(system_error_interrupt_flag_clr), .bus_ready(bus_ready), .data_perr(data_perr), .addr_perr(aperr),
        .target_perr(1'b0), .buf_perr(buf_perr), .buf_is_tx(is_tx), .tx_active(tx_act),
        .tx_bytes(tx_bytes), .tx_byte_end(b_end), .busy(busy), .addr_valid(addr_valid), .addr(addr),
        .frame(frame), .irdy(irdy), .wr(wr), .byte_en(byte_en), .wdata(wdata), .rd_take(rd_take),
        .done(done), .init_done(init_done), .system_error_interrupt_flag(flag), .intr(intr),
        .stop_set(stop_set), .bpe_tx(bpe_tx), .bpe_rx(bpe_rx), .tx_abort(tx_abort), .tx_bad_fcs(tx_bad_fcs));
    // bus monitor: records address phases, completed data phases and master wait states
    always @(posedge mclk) begin
        if (addr_valid === 1'b1 && na < 8) addrs[na++] = addr;
        if (irdy === 1'b1 && bus_ready === 1'b1 && nd < 8) begin
            wds[nd] = wdata;
            bes[nd++] = byte_en;
        end
        if (frame === 1'b1 && irdy === 1'b0 && addr_valid === 1'b0) nw++;
        nstop += (stop_set === 1'b1);
        nab += (tx_abort === 1'b1);
        nfcs += (tx_bad_fcs === 1'b1);
        nbpe += (bpe_tx === 1'b1);
        nbr += (bpe_rx === 1'b1);
        nid += (init_done === 1'b1);
        nrt += (rd_take === 1'b1);
    end
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one request through the sequencer, waiting boundedly for done
    task automatic run(input dip_op_t o, input logic ch);
        int n;
        {na, nd, nw, nstop, nab, nfcs, nbpe, nbr, nid, nrt} = '0;
        @(posedge mclk);
        op <= o;
        chain <= ch;
        req <= 1'b1;
        @(posedge mclk);
        req <= 1'b0;
        for (n = 0; n < 100 && done !== 1'b1; n++) @(posedge mclk);
        if (n == 100) begin
            miscompares++;
            finish_test();
        end
        repeat (3) @(posedge mclk);
    endtask
    task automatic init_nonburst;
        run(DIP_OP_INIT, 1'b0);
        chk(na, 2);
        chk(addrs[1] - addrs[0], 4);
        chk(nd, 2);
        chk(nw, 0);
        chk(nrt, 2);
        chk(busy, 0);
        chk(wr, 0);
    endtask
    task automatic init_burst;
        bre <= 1'b1;
        run(DIP_OP_INIT, 1'b0);
        chk(na, 1);
        chk(addrs[0][1:0], 0);
        chk(nd, 2);
    endtask
    // two 32-bit periods already ran, so the fourth one closes that sequence
    task automatic init_periods;
        run(DIP_OP_INIT, 1'b0);
        chk(nid, 0);
        run(DIP_OP_INIT, 1'b0);
        chk(nid, 1);
        s32 <= 1'b0;
        repeat (2) begin
            run(DIP_OP_INIT, 1'b0);
            chk(nid, 0);
        end
        run(DIP_OP_INIT, 1'b0);
        chk(nid, 1);
    endtask
    task automatic desc_read;
        style <= DIP_STYLE_32_BURST;
        run(DIP_OP_DRD, 1'b0);
        chk(na, 1);
        chk({bes[0], bes[1]}, 8'hff);
        chk(wr, 0);
        style <= DIP_STYLE_32;
        run(DIP_OP_DRD, 1'b0);
        chk(na, 2);
    endtask
    task automatic desc_write;
        bwe <= 1'b1;
        run(DIP_OP_DWR, 1'b0);
        chk(na, 2);
        chk(nw, 2);
        chk({bes[0], bes[1]}, 8'hfc);
        chk(wds[0], 32'h1234_5678);
        chk(wds[1], 32'h8000_0000);
        chk(wr, 1);
        style <= DIP_STYLE_32_BURST;
        run(DIP_OP_DWR, 1'b0);
        chk(na, 1);
        chk(nw, 2);
        style <= DIP_STYLE_16;
        run(DIP_OP_DWR, 1'b1);
        chk(nd, 1);
        chk(bes[0], DIP_BE_TOP_BYTE);
        style <= DIP_STYLE_32;
    endtask
    task automatic parity_cases;
        system_error_interrupt_flag_en <= 1'b1;
        perr_on <= 1'b1;
        run(DIP_OP_INIT, 1'b0);
        chk({flag, intr}, 2'b11);
        chk(nstop, 0);
        system_error_interrupt_flag_clr <= 1'b1;
        @(posedge mclk);
        system_error_interrupt_flag_clr <= 1'b0;
        adv <= 1'b1; // style is 2 when the enable goes on
        @(posedge mclk);
        chk(flag, 0);
        run(DIP_OP_INIT, 1'b0);
        chk(nstop > 0, 1);
        run(DIP_OP_DRD, 1'b0);
        chk(nstop > 0, 1);
        perr_on <= 1'b0;
        aperr <= 1'b1;
        run(DIP_OP_DRD, 1'b0);
        chk(nstop, 0);
        aperr <= 1'b0;
    endtask
    // short frame is cut at once; long one ends with a bad fcs on a byte boundary; rx only marks
    task automatic buffer_error(input logic tx, input logic [15:0] sent, input logic runt);
        @(posedge mclk);
        {nab, nfcs, nbpe, nbr} = '0;
        tx_act <= 1'b1;
        tx_bytes <= sent;
        b_end <= 1'b1;
        is_tx <= tx;
        buf_perr <= 1'b1;
        @(posedge mclk);
        buf_perr <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(nbpe, tx);
        chk(nbr, !tx);
        chk({nab > 0, nfcs > 0}, tx ? {runt, !runt} : 2'b00);
        tx_act <= 1'b0;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        init_nonburst();
        init_burst();
        init_periods();
        desc_read();
        desc_write();
        parity_cases();
        buffer_error(1'b1, 16'h0010, 1'b1);
        buffer_error(1'b1, 16'h0040, 1'b0);
        buffer_error(1'b0, 16'h0040, 1'b0);
        finish_test();
    end
endmodule
